// >>> shared/cid_irq_request_consts.svh
// register offsets, reset values and timing counts of the caller-id status block
`ifndef CID_IRQ_REQUEST_CONSTS_SVH
`define CID_IRQ_REQUEST_CONSTS_SVH
`define CID_IRQ_REQUEST_ADDR_LINE_STATUS   8'hB1
`define CID_IRQ_REQUEST_ADDR_EVENT_FLAGS   8'hB2
`define CID_IRQ_REQUEST_ADDR_PRESENT_LIMIT 8'hBE
`define CID_IRQ_REQUEST_ADDR_ABSENT_LIMIT  8'hBF
`define CID_IRQ_REQUEST_RST_LINE_STATUS    8'h00
`define CID_IRQ_REQUEST_RST_EVENT_FLAGS    8'h00
`define CID_IRQ_REQUEST_RST_PRESENT_LIMIT  8'h0F
`define CID_IRQ_REQUEST_RST_ABSENT_LIMIT   8'h0F
`define CID_IRQ_REQUEST_BIT_RING           0
`define CID_IRQ_REQUEST_BIT_ALERT          1
`define CID_IRQ_REQUEST_BIT_BYTE_READY     2
`define CID_IRQ_REQUEST_BIT_TONE_DECODE    3
`define CID_IRQ_REQUEST_BIT_CARRIER        4
`define CID_IRQ_REQUEST_BIT_FSK_VALUE      5
`define CID_IRQ_REQUEST_BIT_FSK_CLOCK      6
`define CID_IRQ_REQUEST_FLAG_RING          0
`define CID_IRQ_REQUEST_FLAG_ALERT         1
`define CID_IRQ_REQUEST_FLAG_BYTE_READY    2
`define CID_IRQ_REQUEST_FLAG_TONE_DECODE   3
`define CID_IRQ_REQUEST_FLAG_FSK_CLOCK     4
`define CID_IRQ_REQUEST_GUARD_TICK_NS      858200
`define CID_IRQ_REQUEST_CLOCK_PERIOD_NS    50
`define CID_IRQ_REQUEST_GUARD_TICK_CYCLES  (`CID_IRQ_REQUEST_GUARD_TICK_NS / `CID_IRQ_REQUEST_CLOCK_PERIOD_NS)
`endif

// >>> shared/cid_irq_request_pkg.sv
// types of the caller-id status block
package cid_irq_request_pkg;
  typedef struct packed {
    logic fsk_bit_clock;
    logic fsk_bit_value;
    logic carrier_present;
    logic tone_decode_ready;
    logic fsk_byte_ready;
    logic raw_alert_tone_detect;
    logic ring_detected;
  } cid_irq_request_raw_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cid_irq_request_bus_t;

  typedef enum logic [1:0] {
    CID_IRQ_REQUEST_IDLE    = 2'b00,
    CID_IRQ_REQUEST_QUAL_ON = 2'b01,
    CID_IRQ_REQUEST_TONE_ON = 2'b11,
    CID_IRQ_REQUEST_QUAL_OFF = 2'b10
  } cid_irq_request_guard_state_t;
endpackage

// >>> src/cid_irq_request_status_flags.sv
// caller-id live status, event flags and alert-tone guard timer
// How it works
// RQ1 - line status read-only, hardware driven, resets zero
// RQ2 - fsk bit clock and value shown live
// RQ3 - carrier bit follows fsk carrier detect
// RQ4 - tone decode bit follows dtmf ready
// RQ5 - byte ready bit follows assembled fsk byte
// RQ6 - alert bit shows guard-qualified tone
// RQ7 - ring bit follows ring or reversal detect
// RQ8 - fsk clock rise sets sticky event flag
// RQ9 - tone decode rise sets sticky flag
// RQ10 - byte ready rise sets sticky flag
// RQ11 - alert rise sets sticky flag
// RQ12 - ring rise sets sticky flag
// RQ13 - guard timer ticks every 0.8582 ms
// RQ14 - present limit resets to 0x0F
// RQ15 - raw tone rise starts count from zero
// RQ16 - count equal present limit accepts tone
// RQ17 - raw tone fall aborts presence count
// RQ18 - raw tone fall starts absence count
// RQ19 - count equal absent limit ends tone
// RQ20 - raw tone rise aborts absence count
// RQ21 - absent limit resets to 0x0F
// RQ22 - interrupt request is OR of flags
// RQ23 - alert bit set/cleared by qualification ends
// RQ24 - write zero clears flag, set wins
`timescale 1ns/10ps
`include "cid_irq_request_consts.svh"
module cid_irq_request_status_flags
#(
  parameter int TICK_CYCLES = `CID_IRQ_REQUEST_GUARD_TICK_CYCLES
)
(
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  input  wire logic              i_enable,
  input  wire cid_irq_request_pkg::cid_irq_request_raw_t i_raw,
  input  wire cid_irq_request_pkg::cid_irq_request_bus_t i_bus,
  output logic [7:0]             o_rdata,
  output logic [7:0]             o_line_status,
  output logic                   o_cid_irq_request
);
  // the tick counter is 16 bits wide and a tick needs at least two cycles
  generate
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
    begin : g_bad_tick
      $error("TICK_CYCLES out of range");
    end
  endgenerate

  localparam int RAW_W = $bits(cid_irq_request_pkg::cid_irq_request_raw_t);

  typedef struct packed {
    logic [7:0]                  line_status;
    logic [4:0]                  flags;
    logic [7:0]                  present_limit;
    logic [7:0]                  absent_limit;
    logic [7:0]                  guard_count;
    logic [15:0]                 tick_count;
    cid_irq_request_pkg::cid_irq_request_guard_state_t guard_state;
    logic                        raw_tone_prev;
    logic [7:0]                  rdata;
    logic                        irq;
  } cid_irq_request_state_t;

  cid_irq_request_state_t  st_reg;
  cid_irq_request_state_t  st_next;
  cid_irq_request_pkg::cid_irq_request_raw_t raw_sync;
  logic [RAW_W-1:0]    raw_vec;
  logic [5:0]          raw_direct;

  genvar gi;
  generate
    for (gi = 0; gi < RAW_W; gi++)
    begin : g_sync
      cid_irq_request_sync u_sync
      (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_enable  (i_enable),
        .i_async   (i_raw[gi]),
        .o_level   (raw_vec[gi])
      );
    end
  endgenerate

  assign raw_sync = cid_irq_request_pkg::cid_irq_request_raw_t'(raw_vec);
  assign raw_direct = {raw_vec[6:2], raw_vec[0]};

  logic [7:0] status_now;
  logic [4:0] rise;
  logic       tick;
  logic       tone_alert;

  always_comb
  begin
    st_next = st_reg;
    tick = (st_reg.tick_count == 16'(TICK_CYCLES - 1));
    tone_alert = st_reg.line_status[`CID_IRQ_REQUEST_BIT_ALERT];

    // guard-time qualification of the raw alert tone
    if (tick)
    begin
      st_next.tick_count = 16'h0000;
    end
    else
    begin
      st_next.tick_count = st_reg.tick_count + 16'h0001;  // RQ13
    end
    st_next.raw_tone_prev = raw_sync.raw_alert_tone_detect;
    case (st_reg.guard_state)
      cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE:
      begin
        if (raw_sync.raw_alert_tone_detect && !st_reg.raw_tone_prev)
        begin
          st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_ON;  // RQ15
          st_next.guard_count = 8'h00;
          st_next.tick_count = 16'h0000;
        end
      end
      cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_ON:
      begin
        if (!raw_sync.raw_alert_tone_detect)
        begin
          st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE;  // RQ17
          st_next.guard_count = 8'h00;
        end
        else if (st_reg.guard_count == st_reg.present_limit)
        begin
          st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_TONE_ON;  // RQ16
          st_next.guard_count = 8'h00;
          tone_alert = 1'b1;  // RQ23
        end
        else if (tick)
        begin
          st_next.guard_count = st_reg.guard_count + 8'h01;
        end
      end
      cid_irq_request_pkg::CID_IRQ_REQUEST_TONE_ON:
      begin
        if (!raw_sync.raw_alert_tone_detect)
        begin
          st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_OFF;  // RQ18
          st_next.guard_count = 8'h00;
          st_next.tick_count = 16'h0000;
        end
      end
      cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_OFF:
      begin
        if (raw_sync.raw_alert_tone_detect)
        begin
          st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_TONE_ON;  // RQ20
          st_next.guard_count = 8'h00;
        end
        else if (st_reg.guard_count == st_reg.absent_limit)
        begin
          st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE;  // RQ19
          st_next.guard_count = 8'h00;
          tone_alert = 1'b0;  // RQ23
        end
        else if (tick)
        begin
          st_next.guard_count = st_reg.guard_count + 8'h01;
        end
      end
      default:
      begin
        st_next.guard_state = cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE;
      end
    endcase

    // live status, driven by hardware only
    status_now = 8'h00;
    status_now[`CID_IRQ_REQUEST_BIT_FSK_CLOCK] = raw_sync.fsk_bit_clock;  // RQ2
    status_now[`CID_IRQ_REQUEST_BIT_FSK_VALUE] = raw_sync.fsk_bit_value;  // RQ2
    status_now[`CID_IRQ_REQUEST_BIT_CARRIER] = raw_sync.carrier_present;  // RQ3
    status_now[`CID_IRQ_REQUEST_BIT_TONE_DECODE] = raw_sync.tone_decode_ready;  // RQ4
    status_now[`CID_IRQ_REQUEST_BIT_BYTE_READY] = raw_sync.fsk_byte_ready;  // RQ5
    status_now[`CID_IRQ_REQUEST_BIT_ALERT] = tone_alert;  // RQ6
    status_now[`CID_IRQ_REQUEST_BIT_RING] = raw_sync.ring_detected;  // RQ7
    st_next.line_status = status_now;  // RQ1

    // rising edges of the five status bits that have event flags
    rise = 5'b00000;
    rise[`CID_IRQ_REQUEST_FLAG_FSK_CLOCK] = status_now[`CID_IRQ_REQUEST_BIT_FSK_CLOCK]
                                 & ~st_reg.line_status[`CID_IRQ_REQUEST_BIT_FSK_CLOCK];  // RQ8
    rise[`CID_IRQ_REQUEST_FLAG_TONE_DECODE] = status_now[`CID_IRQ_REQUEST_BIT_TONE_DECODE]
                                   & ~st_reg.line_status[`CID_IRQ_REQUEST_BIT_TONE_DECODE];  // RQ9
    rise[`CID_IRQ_REQUEST_FLAG_BYTE_READY] = status_now[`CID_IRQ_REQUEST_BIT_BYTE_READY]
                                  & ~st_reg.line_status[`CID_IRQ_REQUEST_BIT_BYTE_READY];  // RQ10
    rise[`CID_IRQ_REQUEST_FLAG_ALERT] = status_now[`CID_IRQ_REQUEST_BIT_ALERT]
                             & ~st_reg.line_status[`CID_IRQ_REQUEST_BIT_ALERT];  // RQ11
    rise[`CID_IRQ_REQUEST_FLAG_RING] = status_now[`CID_IRQ_REQUEST_BIT_RING]
                            & ~st_reg.line_status[`CID_IRQ_REQUEST_BIT_RING];  // RQ12

    // register writes; status register ignores writes
    if (i_bus.wr)
    begin
      if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_PRESENT_LIMIT)
      begin
        st_next.present_limit = i_bus.wdata;
      end
      else if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_ABSENT_LIMIT)
      begin
        st_next.absent_limit = i_bus.wdata;
      end
      else if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_EVENT_FLAGS)
      begin
        st_next.flags = st_reg.flags & i_bus.wdata[4:0];  // RQ24
      end
    end
    st_next.flags = st_next.flags | rise;  // RQ24

    st_next.irq = |st_next.flags;  // RQ22

    // read data stands in the cycle after the strobe only
    st_next.rdata = 8'h00;
    if (i_bus.rd)
    begin
      if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_LINE_STATUS)
      begin
        st_next.rdata = st_reg.line_status;
      end
      else if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_EVENT_FLAGS)
      begin
        st_next.rdata = {3'b000, st_reg.flags};
      end
      else if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_PRESENT_LIMIT)
      begin
        st_next.rdata = st_reg.present_limit;
      end
      else if (i_bus.addr == `CID_IRQ_REQUEST_ADDR_ABSENT_LIMIT)
      begin
        st_next.rdata = st_reg.absent_limit;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_reg <= '0;
      st_reg.line_status <= `CID_IRQ_REQUEST_RST_LINE_STATUS;  // RQ1
      st_reg.flags <= 5'(`CID_IRQ_REQUEST_RST_EVENT_FLAGS);
      st_reg.present_limit <= `CID_IRQ_REQUEST_RST_PRESENT_LIMIT;  // RQ14
      st_reg.absent_limit <= `CID_IRQ_REQUEST_RST_ABSENT_LIMIT;  // RQ21
      st_reg.guard_state <= cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE;
    end
    else if (i_enable)
    begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_line_status = st_reg.line_status;
  assign o_cid_irq_request = st_reg.irq;

  a_flag_set_on_rise: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_enable && $rose(st_reg.line_status[`CID_IRQ_REQUEST_BIT_RING])
    |-> st_reg.flags[`CID_IRQ_REQUEST_FLAG_RING])  // RQ12
    else $error("ring flag not set on ring rise");

  a_flag_holds: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $fell(st_reg.flags[`CID_IRQ_REQUEST_FLAG_BYTE_READY]) |->
    $past(i_bus.wr) && $past(i_bus.addr) == `CID_IRQ_REQUEST_ADDR_EVENT_FLAGS)  // RQ10
    else $error("byte flag fell without a clear");

  a_irq_is_or: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    ##1 o_cid_irq_request == (|st_reg.flags))  // RQ22
    else $error("irq does not match flags");

  a_status_bit7_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st_reg.line_status[7] == 1'b0)  // RQ1
    else $error("reserved status bit set");

  // guard-time steps as named sequences
  sequence s_present_due;
    i_enable && st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_ON
    && raw_sync.raw_alert_tone_detect && st_reg.guard_count == st_reg.present_limit;
  endsequence

  sequence s_tone_taken;
    st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_TONE_ON ##1 st_reg.line_status[`CID_IRQ_REQUEST_BIT_ALERT];
  endsequence

  sequence s_absent_due;
    i_enable && st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_OFF
    && !raw_sync.raw_alert_tone_detect && st_reg.guard_count == st_reg.absent_limit;
  endsequence

  sequence s_tone_gone;
    st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE ##1 !st_reg.line_status[`CID_IRQ_REQUEST_BIT_ALERT];
  endsequence

  a_present_accept: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ16
    s_present_due |=> s_tone_taken)
    else $error("tone not accepted at present limit");

  a_present_abort: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_enable && st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_ON
    && !raw_sync.raw_alert_tone_detect
    |=> st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE && st_reg.guard_count == 8'h00)  // RQ17
    else $error("presence count not aborted");

  a_absent_end: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ19
    s_absent_due |=> s_tone_gone)
    else $error("tone not ended at absent limit");

  a_absent_abort: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_enable && st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_QUAL_OFF
    && raw_sync.raw_alert_tone_detect
    |=> st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_TONE_ON)  // RQ20
    else $error("absence count not aborted");

  a_count_starts_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_enable && st_reg.guard_state == cid_irq_request_pkg::CID_IRQ_REQUEST_IDLE
    && raw_sync.raw_alert_tone_detect && !st_reg.raw_tone_prev
    |=> st_reg.guard_count == 8'h00 && st_reg.tick_count == 16'h0000)  // RQ15
    else $error("guard count did not start at zero");

  a_status_follows: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ3
    i_enable |=> {st_reg.line_status[6:2], st_reg.line_status[0]} == $past(raw_direct))
    else $error("status bits do not follow the detectors");

  a_set_wins: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ24
    i_enable && (|rise) |=> (st_reg.flags & $past(rise)) == $past(rise))
    else $error("flag rise lost");

  a_flag_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ24
    i_enable && i_bus.wr && i_bus.addr == `CID_IRQ_REQUEST_ADDR_EVENT_FLAGS
    |=> st_reg.flags == (($past(st_reg.flags) & 5'($past(i_bus.wdata))) | $past(rise)))
    else $error("flag write did not clear as written");

  a_tick_wrap: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ13
    i_enable && tick |=> st_reg.tick_count == 16'h0000)
    else $error("guard tick did not wrap");

  a_present_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ14
    i_enable && i_bus.wr && i_bus.addr == `CID_IRQ_REQUEST_ADDR_PRESENT_LIMIT
    |=> st_reg.present_limit == $past(i_bus.wdata))
    else $error("present limit write lost");

  a_absent_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // RQ21
    i_enable && i_bus.wr && i_bus.addr == `CID_IRQ_REQUEST_ADDR_ABSENT_LIMIT
    |=> st_reg.absent_limit == $past(i_bus.wdata))
    else $error("absent limit write lost");
endmodule

// >>> src/cid_irq_request_sync.sv
// three-stage synchroniser for one asynchronous input with agreement filter
`timescale 1ns/10ps
module cid_irq_request_sync
(
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_enable,
  input  wire logic i_async,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } cid_irq_request_sync_state_t;

  cid_irq_request_sync_state_t st_reg;
  cid_irq_request_sync_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a change counts only once the second and third stages agree
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_reg <= '0;
    end
    else if (i_enable)
    begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.lvl;
endmodule

// >>> verification/cid_irq_request_line_model.sv
// line-side detector model that drives the raw caller-id signals
`timescale 1ns/10ps
module cid_irq_request_line_model
(
  input  wire logic           i_clock,
  output cid_irq_request_pkg::cid_irq_request_raw_t o_raw
);
  initial o_raw = '0;

  // levels change just after a rising edge and then hold until the next command
  task automatic set_line(input logic [6:0] lvl);
    @(posedge i_clock);
    o_raw <= cid_irq_request_pkg::cid_irq_request_raw_t'(lvl);
  endtask
endmodule

// >>> verification/tb_cid_irq_request_status_flags.sv
// self-checking testbench of the caller-id status and flag block
`timescale 1ns/10ps
module tb_cid_irq_request_status_flags;
  logic                i_clock;
  logic                i_sys_rst;
  logic                i_enable;
  cid_irq_request_pkg::cid_irq_request_raw_t raw;
  cid_irq_request_pkg::cid_irq_request_bus_t bus;
  logic [7:0]          o_rdata;
  logic [7:0]          o_line_status;
  logic                o_cid_irq_request;
  logic [7:0]          rd_val;
  int                  n_fail = 0;
  int                  n_checks = 0;
  int                  cycles = 0;

  cid_irq_request_line_model cid_irq_request_line_model_i (.i_clock(i_clock), .o_raw(raw));

  cid_irq_request_status_flags #(.TICK_CYCLES(4)) cid_irq_request_status_flags_i
  (
    .i_clock           (i_clock),
    .i_sys_rst         (i_sys_rst),
    .i_enable          (i_enable),
    .i_raw             (raw),
    .i_bus             (bus),
    .o_rdata           (o_rdata),
    .o_line_status     (o_line_status),
    .o_cid_irq_request (o_cid_irq_request)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task give_verdict;
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_fail++;
      give_verdict;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge i_clock);
    bus.wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge i_clock);
    bus.rd   <= 1'b0;
    #1;
    rd_val = o_rdata;
    chk(rd_val, exp);
  endtask

  task automatic t_reset;
    rd_chk(8'hB1, 8'h00);
    rd_chk(8'hB2, 8'h00);
    rd_chk(8'hBE, 8'h0F);
    rd_chk(8'hBF, 8'h0F);
    rd_chk(8'h55, 8'h00);
    chk({7'h00, o_cid_irq_request}, 8'h00);
  endtask

  task automatic t_regs;
    bus_wr(8'hB1, 8'hFF);
    rd_chk(8'hB1, 8'h00);
    bus_wr(8'hBE, 8'hA5);
    bus_wr(8'hBF, 8'h5A);
    rd_chk(8'hBE, 8'hA5);
    rd_chk(8'hBF, 8'h5A);
    bus_wr(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
  endtask

  // each live input but the alert tone alone, then released; event flags accumulate and stick
  task automatic t_live;
    int         bits[6] = '{0, 2, 3, 4, 5, 6};
    int         fbit[6] = '{0, 2, 3, -1, -1, 4};
    logic [7:0] flags;
    flags = 8'h00;
    for (int k = 0; k < 6; k++)
    begin
      cid_irq_request_line_model_i.set_line(7'h01 << bits[k]);
      wait_cyc(10);
      chk(o_line_status, 8'h01 << bits[k]);
      if (fbit[k] >= 0)
        flags[fbit[k]] = 1'b1;
      rd_chk(8'hB2, flags);
      cid_irq_request_line_model_i.set_line(7'h00);
      wait_cyc(10);
      chk(o_line_status, 8'h00);
      rd_chk(8'hB2, flags);
    end
    chk({7'h00, o_cid_irq_request}, 8'h01);
  endtask

  task automatic t_clear;
    bus_wr(8'hB2, 8'hFE);
    rd_chk(8'hB2, 8'h1C);
    bus_wr(8'hB2, 8'h00);
    rd_chk(8'hB2, 8'h00);
    wait_cyc(2);
    chk({7'h00, o_cid_irq_request}, 8'h00);
  endtask

  // short pulses never reach the limit of three ticks when the count restarts
  task automatic t_guard;
    bus_wr(8'hBE, 8'h03);
    bus_wr(8'hBF, 8'h03);
    cid_irq_request_line_model_i.set_line(7'h02);
    wait_cyc(6);
    chk(o_line_status, 8'h00);
    wait_cyc(40);
    chk(o_line_status, 8'h02);
    rd_chk(8'hB2, 8'h02);
    chk({7'h00, o_cid_irq_request}, 8'h01);
    repeat (4)
    begin
      cid_irq_request_line_model_i.set_line(7'h00);
      wait_cyc(6);
      cid_irq_request_line_model_i.set_line(7'h02);
      wait_cyc(6);
    end
    chk(o_line_status, 8'h02);
    cid_irq_request_line_model_i.set_line(7'h00);
    wait_cyc(40);
    chk(o_line_status, 8'h00);
    repeat (4)
    begin
      cid_irq_request_line_model_i.set_line(7'h02);
      wait_cyc(6);
      cid_irq_request_line_model_i.set_line(7'h00);
      wait_cyc(6);
    end
    chk(o_line_status, 8'h00);
  endtask

  // enable low freezes synchronisers, status and writes
  task automatic t_freeze;
    @(posedge i_clock);
    i_enable <= 1'b0;
    bus_wr(8'hBE, 8'h77);
    cid_irq_request_line_model_i.set_line(7'h01);
    wait_cyc(10);
    chk(o_line_status, 8'h00);
    @(posedge i_clock);
    i_enable <= 1'b1;
    wait_cyc(10);
    chk(o_line_status, 8'h01);
    rd_chk(8'hBE, 8'h03);
    rd_chk(8'hB2, 8'h03);
  endtask

  // reset in mid-run with ring held high: defaults back, ring edge seen after release
  task automatic t_midrst;
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    wait_cyc(2);
    chk(o_line_status, 8'h00);
    chk({7'h00, o_cid_irq_request}, 8'h00);
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd_chk(8'hBE, 8'h0F);
    rd_chk(8'hBF, 8'h0F);
    wait_cyc(6);
    chk(o_line_status, 8'h01);
    rd_chk(8'hB2, 8'h01);
    cid_irq_request_line_model_i.set_line(7'h00);
    wait_cyc(10);
    chk(o_line_status, 8'h00);
  endtask

  initial
  begin
    i_sys_rst = 1'b1;
    i_enable  = 1'b1;
    bus       = '0;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset;
    t_regs;
    t_live;
    t_clear;
    t_guard;
    t_freeze;
    t_midrst;
    give_verdict;
  end
endmodule
